// file: hw/isr_params.svh
// Constants of the I/O sample reporter: field values, encodings, timing.
`ifndef ISR_PARAMS_SVH
`define ISR_PARAMS_SVH
// Sample-set count carried by every report
`define ISR_SAMPLE_SETS 8'h01
// Pin configuration codes
`define ISR_PIN_ANALOG 3'h2
`define ISR_PIN_DIGITAL 3'h3
// Line counts and largest report (1 + 2 + 1 + 2 + 6 * 2 bytes)
`define ISR_NUM_DIO 13
`define ISR_NUM_AIN 6
`define ISR_MAX_BYTES 18
// Text reply characters
`define ISR_CHAR_CR 8'h0D
`define ISR_CHAR_ZERO 8'h30
`define ISR_CHAR_ALPHA 8'h37
// Clock period and one millisecond, both in picoseconds
`define ISR_CLK_PERIOD_PS 4000
`define ISR_MS_PS 1000000000
`define ISR_MS_CYCLES (`ISR_MS_PS / `ISR_CLK_PERIOD_PS)
`endif

// file: hw/isr_pkg.sv
// Types shared by the I/O sample reporter.
package isr_pkg;
	// Emitter state, one-hot
	typedef enum logic [1:0] {
		ISR_STATE_IDLE = 2'b01,
		ISR_STATE_EMIT = 2'b10
	} isr_state_t;
	// What the outgoing stream is for
	typedef enum logic [1:0] {
		ISR_KIND_TEXT = 2'h0,
		ISR_KIND_API = 2'h1,
		ISR_KIND_REMOTE = 2'h2
	} isr_kind_t;
endpackage

// file: hw/isr_reporter.sv
// I/O sample reporter: builds sample reports and streams them out byte by byte.
`include "isr_params.svh"
module isr_reporter
	import isr_pkg::*;
#(
	parameter int MS_CYCLES = `ISR_MS_CYCLES
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic [12:0] gp_line_i,
	input wire logic [38:0] pin_cfg_i,
	input wire logic [95:0] adc_sample_i,
	input wire logic [15:0] sample_period_ms_i,
	input wire logic [12:0] change_watch_mask_i,
	input wire logic force_sample_query_i,
	input wire logic query_via_api_i,
	input wire logic api_mode_i,
	input wire logic [31:0] dest_addr_high_i,
	input wire logic [31:0] dest_addr_low_i,
	input wire logic sleep_enable_i,
	input wire logic wake_hold_active_i,
	input wire logic rx_report_i,
	input wire logic out_ready_i,
	output logic out_valid_o,
	output logic [7:0] out_byte_o,
	output logic out_last_o,
	output logic [1:0] out_kind_o,
	output logic [63:0] out_dest_o,
	output logic busy_o,
	output logic rx_forward_o,
	output logic rx_discard_o
);
	localparam int NB = `ISR_MAX_BYTES;

	// Synchronised digital lines and their previous value
	logic [12:0] line_w, prev_q, prev_d, edge_w;
	// Report store and stream position
	logic [7:0] rep_q [NB], rep_d [NB], bld_b [NB];
	logic [NB-1:0] end_q, end_d, bld_e;
	logic [4:0] len_q, len_d, bld_n, idx_q, idx_d;
	logic [1:0] ph_q, ph_d;
	isr_state_t state_q, state_d;
	isr_kind_t kind_q, kind_d;
	// Output registers
	logic valid_q, valid_d, last_q, last_d, fwd_q, fwd_d, dis_q, dis_d;
	logic [7:0] byte_q, byte_d;
	logic [63:0] dest_q, dest_d;
	// Trigger pending flags and timers
	logic q_pend_q, q_pend_d, c_pend_q, c_pend_d, p_pend_q, p_pend_d;
	logic [31:0] ms_cnt_q, ms_cnt_d;
	logic [15:0] ms_el_q, ms_el_d;
	logic ms_tick_w, awake_w, start_w;
	logic [12:0] dmask_w;
	logic [5:0] amask_w;
	logic text_w;

	isr_sync3 #(.W(13)) u_sync (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.pin_i(gp_line_i),
		.level_o(line_w)
	);

	// Hex digit as an ASCII character
	function automatic logic [7:0] hex_char(input logic [3:0] n);
		hex_char = (n < 4'hA) ? (`ISR_CHAR_ZERO + {4'h0, n}) : (`ISR_CHAR_ALPHA + {4'h0, n});
	endfunction

	// Masks from the pin configuration codes
	always_comb
	begin
		for (int i = 0; i < `ISR_NUM_DIO; i++)
			dmask_w[i] = (pin_cfg_i[i*3 +: 3] == `ISR_PIN_DIGITAL);
		for (int i = 0; i < `ISR_NUM_AIN; i++)
			amask_w[i] = (pin_cfg_i[i*3 +: 3] == `ISR_PIN_ANALOG);
	end

	// Report image built from live lines; holds count, masks, states, readings
	always_comb
	begin
		for (int i = 0; i < NB; i++)
			bld_b[i] = 8'h00;
		bld_e = '0;
		bld_b[0] = `ISR_SAMPLE_SETS;
		bld_e[0] = 1'b1;
		bld_b[1] = {3'h0, dmask_w[12:8]};
		bld_b[2] = dmask_w[7:0];
		bld_e[2] = 1'b1;
		bld_b[3] = {2'h0, amask_w};
		bld_e[3] = 1'b1;
		bld_n = 5'd4;
		// Lines read at the trigger cycle, so an edge is captured at once
		if (|dmask_w)
		begin
			bld_b[bld_n] = {3'h0, line_w[12:8] & dmask_w[12:8]};
			bld_b[bld_n + 5'd1] = line_w[7:0] & dmask_w[7:0];
			bld_e[bld_n + 5'd1] = 1'b1;
			bld_n = bld_n + 5'd2;
		end
		for (int i = 0; i < `ISR_NUM_AIN; i++)
			if (amask_w[i])
			begin
				bld_b[bld_n] = adc_sample_i[i*16+8 +: 8];
				bld_b[bld_n + 5'd1] = adc_sample_i[i*16 +: 8];
				bld_e[bld_n + 5'd1] = 1'b1;
				bld_n = bld_n + 5'd2;
			end
	end

	// Triggers, timers and the change monitor
	always_comb
	begin
		awake_w = !sleep_enable_i || wake_hold_active_i;
		ms_tick_w = (ms_cnt_q == 32'(MS_CYCLES - 1));
		ms_cnt_d = ms_cnt_q;
		ms_el_d = ms_el_q;
		edge_w = (line_w ^ prev_q) & change_watch_mask_i;
		prev_d = line_w;
		start_w = (state_q == ISR_STATE_IDLE) && (q_pend_q || c_pend_q || p_pend_q);
		if (sample_period_ms_i == 16'h0000)
		begin
			ms_cnt_d = '0;
			ms_el_d = '0;
		end
		else if (awake_w)
		begin
			ms_cnt_d = ms_tick_w ? 32'h0000_0000 : ms_cnt_q + 32'h0000_0001;
			if (ms_tick_w)
				ms_el_d = (ms_el_q + 16'h0001 >= sample_period_ms_i) ? 16'h0000
					: ms_el_q + 16'h0001;
		end
		// Set wins over the take; query first, then change, then periodic
		q_pend_d = force_sample_query_i || (q_pend_q && !start_w);
		c_pend_d = (|edge_w) || (c_pend_q && !(start_w && !q_pend_q));
		p_pend_d = (sample_period_ms_i != 16'h0000) && ((awake_w && ms_tick_w
			&& ms_el_q + 16'h0001 >= sample_period_ms_i)
			|| (p_pend_q && !(start_w && !q_pend_q && !c_pend_q)));
		fwd_d = rx_report_i && api_mode_i;
		dis_d = rx_report_i && !api_mode_i;
	end

	// Emitter: loads the image on a trigger, then steps byte by byte
	always_comb
	begin
		state_d = state_q;
		kind_d = kind_q;
		rep_d = rep_q;
		end_d = end_q;
		len_d = len_q;
		idx_d = idx_q;
		ph_d = ph_q;
		valid_d = valid_q;
		byte_d = byte_q;
		last_d = last_q;
		dest_d = dest_q;
		text_w = (kind_q == ISR_KIND_TEXT);
		case (state_q)
			ISR_STATE_IDLE:
			begin
				if (start_w)
				begin
					rep_d = bld_b;
					end_d = bld_e;
					len_d = bld_n;
					idx_d = 5'd0;
					ph_d = 2'd0;
					valid_d = 1'b1;
					last_d = 1'b0;
					state_d = ISR_STATE_EMIT;
					if (q_pend_q)
					begin
						kind_d = query_via_api_i ? ISR_KIND_API : ISR_KIND_TEXT;
						dest_d = 64'h0000_0000_0000_0000;
						byte_d = query_via_api_i ? bld_b[0] : hex_char(bld_b[0][7:4]);
					end
					else
					begin
						kind_d = ISR_KIND_REMOTE;
						dest_d = {dest_addr_high_i, dest_addr_low_i};
						byte_d = bld_b[0];
					end
				end
			end
			ISR_STATE_EMIT:
			begin
				if (out_ready_i)
				begin
					if (last_q)
					begin
						valid_d = 1'b0;
						last_d = 1'b0;
						state_d = ISR_STATE_IDLE;
					end
					else if (text_w)
					begin
						if (ph_q == 2'd0)
							ph_d = 2'd1;
						else if (ph_q == 2'd1 && end_q[idx_q])
							ph_d = 2'd2;
						else
						begin
							ph_d = 2'd0;
							idx_d = idx_q + 5'd1;
						end
						case (ph_d)
							2'd0: byte_d = hex_char(rep_q[idx_d][7:4]);
							2'd1: byte_d = hex_char(rep_q[idx_d][3:0]);
							default: byte_d = `ISR_CHAR_CR;
						endcase
						last_d = (ph_d == 2'd2) && (idx_d == len_q - 5'd1);
					end
					else
					begin
						idx_d = idx_q + 5'd1;
						byte_d = rep_q[idx_d];
						last_d = (idx_d == len_q - 5'd1);
					end
				end
			end
			default:
			begin
				state_d = ISR_STATE_IDLE;
				valid_d = 1'b0;
			end
		endcase
	end

	// Register all state
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			state_q <= ISR_STATE_IDLE;
			kind_q <= ISR_KIND_TEXT;
			for (int i = 0; i < NB; i++)
				rep_q[i] <= 8'h00;
			end_q <= '0;
			len_q <= '0;
			idx_q <= '0;
			ph_q <= '0;
			valid_q <= 1'b0;
			byte_q <= 8'h00;
			last_q <= 1'b0;
			dest_q <= '0;
			prev_q <= '0;
			q_pend_q <= 1'b0;
			c_pend_q <= 1'b0;
			p_pend_q <= 1'b0;
			ms_cnt_q <= '0;
			ms_el_q <= '0;
			fwd_q <= 1'b0;
			dis_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			kind_q <= kind_d;
			rep_q <= rep_d;
			end_q <= end_d;
			len_q <= len_d;
			idx_q <= idx_d;
			ph_q <= ph_d;
			valid_q <= valid_d;
			byte_q <= byte_d;
			last_q <= last_d;
			dest_q <= dest_d;
			prev_q <= prev_d;
			q_pend_q <= q_pend_d;
			c_pend_q <= c_pend_d;
			p_pend_q <= p_pend_d;
			ms_cnt_q <= ms_cnt_d;
			ms_el_q <= ms_el_d;
			fwd_q <= fwd_d;
			dis_q <= dis_d;
		end
	end

	assign out_valid_o = valid_q;
	assign out_byte_o = byte_q;
	assign out_last_o = last_q;
	assign out_kind_o = kind_q;
	assign out_dest_o = dest_q;
	assign busy_o = state_q[1];
	assign rx_forward_o = fwd_q;
	assign rx_discard_o = dis_q;

	// Checks
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (rst_i);

	sets_one_a: assert property (start_w && !q_pend_q |=> out_byte_o == 8'h01)
		else $error("first report byte is not one");
	text_first_a: assert property (start_w && q_pend_q && !query_via_api_i
		|=> out_byte_o == 8'h30 && out_kind_o == ISR_KIND_TEXT)
		else $error("text reply does not start with digit zero");
	api_kind_a: assert property (start_w && q_pend_q && query_via_api_i
		|=> out_kind_o == ISR_KIND_API && out_byte_o == 8'h01)
		else $error("API reply kind or first byte wrong");
	len_a: assert property (start_w |=> len_q == 5'd4 + ((|$past(dmask_w)) ? 5'd2 : 5'd0)
		+ 5'($countones($past(amask_w)) * 2))
		else $error("report length mismatch");
	dmask_hi_a: assert property (start_w |=> rep_q[1][7:5] == 3'h0 && rep_q[3][7:6] == 2'h0)
		else $error("mask upper bits not zero");
	period_off_a: assert property (sample_period_ms_i == 16'h0000 |=> !p_pend_q)
		else $error("periodic sample raised with zero period");
	period_fire_a: assert property (awake_w && ms_tick_w && sample_period_ms_i != 16'h0000
		&& ms_el_q + 16'h0001 >= sample_period_ms_i |=> p_pend_q)
		else $error("period elapsed without a pending sample");
	dest_a: assert property (start_w && !q_pend_q
		|=> out_dest_o == {$past(dest_addr_high_i), $past(dest_addr_low_i)})
		else $error("remote report destination wrong");
	rx_a: assert property (rx_report_i |=> rx_forward_o == $past(api_mode_i)
		&& rx_discard_o == !$past(api_mode_i))
		else $error("received report routing wrong");
	asleep_a: assert property (sleep_enable_i && !wake_hold_active_i
		&& sample_period_ms_i != 16'h0000 |=> $stable(ms_cnt_q))
		else $error("period timer ran while asleep");
	change_a: assert property (state_q == ISR_STATE_IDLE && !start_w && |edge_w
		|=> ##1 state_q == ISR_STATE_EMIT)
		else $error("watched edge did not start a report");

	text_cov: cover property (start_w && q_pend_q && !query_via_api_i ##[1:200] out_last_o);
	remote_cov: cover property (start_w && p_pend_q && !q_pend_q ##[1:60] out_last_o);
	change_cov: cover property (|edge_w ##[1:3] start_w);
endmodule

// file: hw/isr_sync3.sv
// Three-stage pin synchroniser; a new level counts once stages two and three agree.
module isr_sync3 #(
	parameter int W = 13
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic [W-1:0] pin_i,
	output logic [W-1:0] level_o
);
	logic [W-1:0] s1_q, s2_q, s3_q, lvl_q; // Stage one feeds stage two only
	logic [W-1:0] lvl_d;

	// Take a bit only when the last two stages agree
	always_comb
	begin
		lvl_d = ((s2_q ~^ s3_q) & s3_q) | ((s2_q ^ s3_q) & lvl_q);
	end

	// Register stages
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			lvl_q <= '0;
		end
		else
		begin
			s1_q <= pin_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
			lvl_q <= lvl_d;
		end
	end

	assign level_o = lvl_q;
endmodule

// file: verif/isr_sink_model.sv
// Byte sink model on the far side of the report stream.
module isr_sink_model (
	input wire logic core_clk_i,
	input wire logic slow_i,
	output logic ready_o = 1'b1
);
	timeunit 1ns;
	timeprecision 1ps;
	int seed = 4422; // Fixed seed keeps stalls repeatable
	// Ready moves on the falling edge only, never on the sampling edge
	always @(negedge core_clk_i)
	begin
		ready_o <= slow_i ? ($random(seed) % 3 == 0) : 1'b1;
	end
endmodule

// file: verif/tb_isr_reporter.sv
// Testbench of the I/O sample reporter against a queue-based model.
`include "isr_params.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_total++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb_isr_reporter import isr_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int MS = 10; // Short millisecond keeps the run brief
	logic clk = 0, rst = 1, q = 0, via_api = 0, api = 0, slp = 0, wake = 0, rx = 0, slow = 0;
	logic [12:0] line = '0, watch = '0;
	logic [38:0] cfg = '0;
	logic [95:0] adc = '0;
	logic [15:0] per = '0;
	logic [31:0] dest_hi = '0, dest_lo = '0;
	logic vld, rdy, last, busy, fwd, dis;
	logic [7:0] byt;
	logic [1:0] kind;
	logic [63:0] dest;
	int seed = 4422, err_total = 0, checked = 0, cyc = 0, nrep = 0, first_cyc = 0, c1, n0;
	logic [7:0] got_q[$], exp_q[$];
	initial forever #2 clk = ~clk;
	isr_reporter #(.MS_CYCLES(MS)) dut (.core_clk_i(clk), .rst_i(rst), .gp_line_i(line),
		.pin_cfg_i(cfg), .adc_sample_i(adc), .sample_period_ms_i(per),
		.change_watch_mask_i(watch), .force_sample_query_i(q), .query_via_api_i(via_api),
		.api_mode_i(api), .dest_addr_high_i(dest_hi), .dest_addr_low_i(dest_lo),
		.sleep_enable_i(slp), .wake_hold_active_i(wake), .rx_report_i(rx),
		.out_ready_i(rdy), .out_valid_o(vld), .out_byte_o(byt), .out_last_o(last),
		.out_kind_o(kind), .out_dest_o(dest), .busy_o(busy), .rx_forward_o(fwd),
		.rx_discard_o(dis));
	isr_sink_model sink (.core_clk_i(clk), .slow_i(slow), .ready_o(rdy));
	// Gather accepted bytes; note the cycle each report starts
	always @(posedge clk)
	begin
		cyc++;
		if (vld && rdy)
		begin
			if (got_q.size() == 0)
				first_cyc = cyc;
			got_q.push_back(byt);
			if (last)
				nrep++;
		end
	end
	function automatic logic [7:0] hexc(input int v);
		return v < 10 ? `ISR_CHAR_ZERO + 8'(v) : `ISR_CHAR_ALPHA + 8'(v);
	endfunction
	// Expected report from the present pin settings
	task automatic build(input bit txt);
		int dm, am, v;
		int f[$], w[$];
		dm = 0;
		am = 0;
		for (int n = 0; n < 13; n++)
		begin
			if (cfg[3*n+:3] == `ISR_PIN_DIGITAL)
				dm |= 1 << n;
			if (n < 6 && cfg[3*n+:3] == `ISR_PIN_ANALOG)
				am |= 1 << n;
		end
		f = '{int'(`ISR_SAMPLE_SETS), dm, am};
		w = '{1, 2, 1};
		if (dm != 0)
		begin
			f.push_back(line & dm);
			w.push_back(2);
		end
		for (int c = 0; c < 6; c++)
			if (am[c])
			begin
				f.push_back(adc[16*c+:16]);
				w.push_back(2);
			end
		for (int i = 0; i < f.size(); i++)
		begin
			for (int b = w[i] - 1; b >= 0; b--)
			begin
				v = (f[i] >> (8 * b)) & 255;
				if (txt)
				begin
					exp_q.push_back(hexc(v >> 4));
					exp_q.push_back(hexc(v & 15));
				end
				else
					exp_q.push_back(8'(v));
			end
			if (txt)
				exp_q.push_back(`ISR_CHAR_CR);
		end
	endtask
	// Wait for one whole report (bounded) and compare it
	task automatic check_rep(input logic [1:0] k, input logic [63:0] d, input bit txt);
		n0 = nrep;
		for (int n = 0; n < 400 && nrep == n0; n++)
			@(negedge clk);
		build(txt);
		`CHK(nrep, n0 + 1)
		`CHK(vld, 1'b0)
		`CHK(busy, 1'b0)
		`CHK(got_q.size(), exp_q.size())
		foreach (exp_q[i]) `CHK(got_q[i], exp_q[i])
		`CHK(kind, k)
		`CHK(dest, d)
		got_q.delete();
		exp_q.delete();
	endtask
	task automatic stop_test();
		$display("checked=%0d err_total=%0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial
	begin
		repeat (20000) @(posedge clk);
		err_total++;
		stop_test();
	end
	initial
	begin
		repeat (5) @(negedge clk);
		rst = 0;
		// Queries: empty, full and random pin sets, binary and text, stalling sink
		for (int t = 0; t < 12; t++)
		begin
			cfg = 39'({$random(seed), $random(seed)});
			if (t == 0)
				cfg = '0;
			if (t == 1)
				cfg = {{7{3'h3}}, {6{3'h2}}};
			adc = {$random(seed), $random(seed), $random(seed)};
			line = 13'($random(seed));
			via_api = t[0];
			slow = t[1];
			repeat (8) @(negedge clk);
			q = 1;
			@(negedge clk);
			q = 0;
			check_rep(via_api ? ISR_KIND_API : ISR_KIND_TEXT, '0, !via_api);
		end
		// Periodic reports and their spacing
		cfg = '0;
		slow = 0;
		dest_hi = $random(seed);
		dest_lo = $random(seed);
		per = 16'h0002;
		check_rep(ISR_KIND_REMOTE, {dest_hi, dest_lo}, 0);
		c1 = first_cyc;
		check_rep(ISR_KIND_REMOTE, {dest_hi, dest_lo}, 0);
		`CHK(first_cyc - c1, 2 * MS)
		// Asleep without wake hold: timer held; awake again: reports resume
		slp = 1;
		repeat (100) @(negedge clk);
		got_q.delete();
		n0 = nrep;
		repeat (100) @(negedge clk);
		`CHK(nrep, n0)
		wake = 1;
		check_rep(ISR_KIND_REMOTE, {dest_hi, dest_lo}, 0);
		per = '0;
		repeat (40) @(negedge clk);
		got_q.delete();
		n0 = nrep;
		repeat (100) @(negedge clk);
		`CHK(nrep, n0)
		// Watched line 12 toggles: immediate remote report; unwatched line is ignored
		cfg = {3'h3, 36'h0_0000_0000};
		watch = 13'h1000;
		repeat (8) @(negedge clk);
		line[12] = ~line[12];
		check_rep(ISR_KIND_REMOTE, {dest_hi, dest_lo}, 0);
		line[0] = ~line[0];
		repeat (30) @(negedge clk);
		`CHK(nrep, n0 + 1)
		// Received reports forwarded only with API framing
		for (int a = 0; a < 2; a++)
		begin
			api = a[0];
			rx = 1;
			@(negedge clk);
			`CHK(fwd, a[0])
			`CHK(dis, !a[0])
			rx = 0;
			@(negedge clk);
			`CHK(fwd | dis, 1'b0)
		end
		stop_test();
	end
endmodule
